/* bdcu_pkg.sv */
package bdcu_pkg;

  // cycles to wait for a free bus cycle before the cpu is frozen
  localparam int unsigned STEAL_LIMIT = 128;
  // handshake is off after reset
  localparam logic        ACK_EN_RST  = 1'b0;

  // hardware command opcodes
  localparam logic [7:0] OP_BACKGROUND     = 8'h90;
  localparam logic [7:0] OP_ACK_ON         = 8'hD5;
  localparam logic [7:0] OP_ACK_OFF        = 8'hD6;
  // firmware command opcodes that change execution
  localparam logic [7:0] OP_RESUME         = 8'h08;
  localparam logic [7:0] OP_RESUME_UNTIL   = 8'h0C;
  localparam logic [7:0] OP_STEP           = 8'h10;
  localparam logic [7:0] OP_RETIRED_RESUME = 8'h18;

  // opcode field positions
  localparam int unsigned OPB_READ  = 5;  // set on every read opcode
  localparam int unsigned OPB_WORD  = 3;  // word access on memory opcodes
  localparam int unsigned OPB_BDMAP = 2;  // debug space mapped in

  typedef enum logic [2:0] {S_IDLE, S_HW, S_FW, S_ENTER, S_LEAVE, S_RETURN} bdcu_cmd_state_t;
  typedef enum logic [1:0] {A_IDLE, A_WAIT, A_ACCESS} bdcu_acc_state_t;

  // byte lanes: bit 1 = high byte (even address), bit 0 = low byte (odd address)
  function automatic logic [1:0] bdcu_lanes(input logic word, input logic a0);
    bdcu_lanes = word ? 2'h3 : (a0 ? 2'h1 : 2'h2);
  endfunction : bdcu_lanes

  // memory opcodes E0/E4/E8/EC/C0/C4/C8/CC
  function automatic logic bdcu_is_mem(input logic [7:0] op);
    bdcu_is_mem = (op[7:6] == 2'h3) && !op[4] && (op[1:0] == 2'h0);
  endfunction : bdcu_is_mem

  // register access opcodes 42..47 and 62..67
  function automatic logic bdcu_is_fw(input logic [7:0] op);
    bdcu_is_fw = (op[7:6] == 2'h1) && (op[4:3] == 2'h0) && (op[2:1] != 2'h0);
  endfunction : bdcu_is_fw

endpackage : bdcu_pkg

/* bdcu_acc_if.sv */
interface bdcu_acc_if;
  logic        req;
  logic        we;
  logic [1:0]  lanes;
  logic [15:0] rdata;
  logic        done;

  // command side asks, access engine answers
  modport cmd (output req, we, lanes, input  rdata, done);
  modport eng (input  req, we, lanes, output rdata, done);
endinterface : bdcu_acc_if

/* bdcu_steal.sv */
module bdcu_steal import bdcu_pkg::*; #(
  parameter int unsigned STEAL_CYCLES = STEAL_LIMIT
) (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // command side
  bdcu_acc_if.eng          acc,
  // cpu bus
  input  wire logic        bus_idle_i,
  input  wire logic        mem_wait_i,
  input  wire logic [15:0] mem_rdata_i,
  output      logic        mem_req_o,
  output      logic        freeze_o
);

  if (STEAL_CYCLES < 1 || STEAL_CYCLES > 255) begin : g_chk
    $error("steal limit must be 1 to 255");
  end

  typedef struct packed {
    bdcu_acc_state_t state;
    logic [7:0]      cnt;
    logic            stolen;
    logic            multi;
    logic            done;
    logic [15:0]     rdata;
  } bdcu_acc_reg_t;

  bdcu_acc_reg_t r_reg, r_next;

  // next state; done blocks a restart while the command side drops req
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    unique case (r_reg.state)
      A_IDLE: if (acc.req && !r_reg.done) begin
        r_next.stolen = 1'b0;
        r_next.multi  = 1'b0;
        r_next.cnt    = 8'h01;
        r_next.state  = bus_idle_i ? A_ACCESS : A_WAIT;
      end
      A_WAIT: if (bus_idle_i) begin
        r_next.state = A_ACCESS;
      end else if (r_reg.cnt == 8'(STEAL_CYCLES)) begin
        r_next.stolen = 1'b1;  // RULE_01
        r_next.state  = A_ACCESS;
      end else begin
        r_next.cnt = r_reg.cnt + 8'h01;
      end
      A_ACCESS: if (!mem_wait_i) begin
        r_next.rdata = mem_rdata_i;
        r_next.done  = 1'b1;
        r_next.state = A_IDLE;
      end else begin
        r_next.multi = 1'b1;  // RULE_03
      end
      default: r_next.state = A_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign mem_req_o = (r_reg.state == A_ACCESS);
  // a found idle cycle leaves the cpu alone; a dragging access stays frozen to its last cycle
  assign freeze_o  = mem_req_o && (r_reg.stolen || r_reg.multi || mem_wait_i);  // RULE_02 RULE_03
  assign acc.done  = r_reg.done;
  assign acc.rdata = r_reg.rdata;

  chk_steal_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_01
    (r_reg.state == A_WAIT && !bus_idle_i && r_reg.cnt == 8'(STEAL_CYCLES)) |=> freeze_o)
    else $error("no steal after wait limit");
  chk_no_early_freeze: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_02
    (r_reg.state == A_WAIT && bus_idle_i) |=> (mem_wait_i || !freeze_o))
    else $error("cpu frozen on single free-cycle access");
  chk_multi_freeze: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_03
    (mem_req_o && mem_wait_i) |=> (freeze_o || !mem_req_o))
    else $error("multi-cycle access not frozen");

endmodule : bdcu_steal

/* bdcu_top.sv */
// Overview of operation
// RULE_01: pending memory command waits for idle bus; after 128 cycles freeze cpu and steal.
// RULE_02: single-cycle access in a free bus cycle leaves the cpu running.
// RULE_03: multi-cycle access keeps the cpu frozen until it completes.
// RULE_04: hardware commands run whether or not debug mode is active.
// RULE_05: debug space mapped in only during that one access cycle.
// RULE_06: with handshake, ack when read data is ready or write completed.
// RULE_07: opcode 90 requests debug entry if enabled; ack on entry.
// RULE_08: D5 turns handshake on and acks; D6 turns it off silently.
// RULE_09: reads carry 16-bit address, return 16 bits; E4/EC mapped, E0/E8 not.
// RULE_10: writes carry address and data; C4/CC mapped, C0/C8 not.
// RULE_11: byte data: odd address in low byte, even address in high byte.
// RULE_12: host issues word accesses only at even addresses.
// RULE_13: user code suspended in debug mode; register commands only there.
// RULE_14: debug window 0x3_FF00 to 0x3_FFFF visible while debug mode active.
// RULE_15: in debug mode each received command is executed as it arrives.
// RULE_16: 62 reads word at X+2, 42 writes word at X+2.
// RULE_17: 63..67 fetch_program_counter,D,X,Y,SP; 43..47 write them.
// RULE_18: 08 resumes user code; ack when debug mode is left.
// RULE_19: 0C resumes user code; ack only when debug mode is re-entered.
// RULE_20: 10 runs one instruction, returns to debug mode, acks on return.
// RULE_21: retired opcode 18 behaves exactly like resume.
// RULE_22: frame is opcode, then 16-bit address and/or 16-bit data.
// RULE_23: entry command while debug not enabled is ignored, cpu not delayed.
// RULE_24: host waits 150 cycles after a read address before reading data.
// RULE_25: register commands outside debug mode and unknown opcodes are ignored, no ack.
module bdcu_top import bdcu_pkg::*; #(
  parameter int unsigned STEAL_CYCLES = STEAL_LIMIT
) (
  // clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESET_N_I,
  // decoded command frames from the serial layer
  input  wire logic        CMD_VALID_I,
  input  wire logic [7:0]  CMD_OPCODE_I,
  input  wire logic [15:0] CMD_ADDR_I,
  input  wire logic [15:0] CMD_DATA_I,
  output      logic        CMD_READY_O,
  // answers to the serial layer
  output      logic        RESP_VALID_O,
  output      logic [15:0] RESP_DATA_O,
  output      logic        ACK_PULSE_O,
  output      logic        ACK_ENABLED_O,
  // cpu debug control
  input  wire logic        DEBUG_ENABLE_I,
  input  wire logic        DEBUG_ACTIVE_I,
  output      logic        BG_REQ_O,
  output      logic        RESUME_O,
  output      logic        STEP_O,
  output      logic        DEBUG_MAP_O,
  // register commands handed to the debug firmware
  output      logic        FW_REQ_O,
  output      logic [7:0]  FW_CODE_O,
  output      logic [15:0] FW_WDATA_O,
  input  wire logic        FW_DONE_I,
  input  wire logic [15:0] FW_RDATA_I,
  // memory bus
  input  wire logic        BUS_IDLE_I,
  input  wire logic        MEM_WAIT_I,
  input  wire logic [15:0] MEM_RDATA_I,
  output      logic        MEM_REQ_O,
  output      logic        MEM_WE_O,
  output      logic        MEM_BD_MAP_O,
  output      logic [1:0]  MEM_LANES_O,
  output      logic [15:0] MEM_ADDR_O,
  output      logic [15:0] MEM_WDATA_O,
  output      logic        FREEZE_O
);

  if (STEAL_CYCLES < 1 || STEAL_CYCLES > 255) begin : g_chk
    $error("steal limit must be 1 to 255");
  end

  typedef struct packed {
    bdcu_cmd_state_t state;
    logic [7:0]      op;
    logic [15:0]     addr;
    logic [15:0]     wdata;
    logic [1:0]      lanes;
    logic            ack_en;
    logic            left;
    logic            ack;
    logic            resp_valid;
    logic [15:0]     resp_data;
    logic            bg_req;
    logic            resume;
    logic            step;
  } bdcu_top_reg_t;

  localparam bdcu_top_reg_t TOP_RST = '{ack_en: ACK_EN_RST, state: S_IDLE, default: '0};

  bdcu_top_reg_t r_reg, r_next;
  logic          accept;
  logic          is_mem;
  logic          is_fw;

  bdcu_acc_if acc_bus ();

  // cycle-steal engine for memory commands
  bdcu_steal #(
    .STEAL_CYCLES (STEAL_CYCLES)
  ) u_steal (
    .clk_i       (CLK_I),
    .rst_n_i     (RESET_N_I),
    .acc         (acc_bus.eng),
    .bus_idle_i  (BUS_IDLE_I),
    .mem_wait_i  (MEM_WAIT_I),
    .mem_rdata_i (MEM_RDATA_I),
    .mem_req_o   (MEM_REQ_O),
    .freeze_o    (FREEZE_O)
  );

  // a new frame is taken when idle, or while waiting on a resume that may never return
  assign accept = CMD_VALID_I && (r_reg.state == S_IDLE || r_reg.state == S_RETURN);
  assign is_mem = bdcu_is_mem(CMD_OPCODE_I);  // RULE_22
  assign is_fw  = bdcu_is_fw(CMD_OPCODE_I);

  // command sequencer
  always_comb begin
    r_next            = r_reg;
    r_next.ack        = 1'b0;
    r_next.resp_valid = 1'b0;
    r_next.bg_req     = 1'b0;
    r_next.resume     = 1'b0;
    r_next.step       = 1'b0;

    // completion of the command in flight
    unique case (r_reg.state)
      S_IDLE: begin
      end
      S_HW: if (acc_bus.done) begin
        if (r_reg.op[OPB_READ]) begin  // RULE_09
          r_next.resp_valid = 1'b1;
          // unused lane reads as zero
          r_next.resp_data  = acc_bus.rdata &
                              {{8{r_reg.lanes[1]}}, {8{r_reg.lanes[0]}}};  // RULE_11
        end
        r_next.ack   = r_reg.ack_en;  // RULE_06
        r_next.state = S_IDLE;
      end
      S_FW: if (FW_DONE_I) begin
        if (r_reg.op[OPB_READ]) begin  // RULE_17
          r_next.resp_valid = 1'b1;
          r_next.resp_data  = FW_RDATA_I;
        end
        r_next.ack   = r_reg.ack_en;  // RULE_06
        r_next.state = S_IDLE;
      end
      S_ENTER: if (DEBUG_ACTIVE_I) begin
        r_next.ack   = r_reg.ack_en;  // RULE_07
        r_next.state = S_IDLE;
      end
      S_LEAVE: if (!DEBUG_ACTIVE_I) begin
        r_next.ack   = r_reg.ack_en;  // RULE_18
        r_next.state = S_IDLE;
      end
      S_RETURN: if (!DEBUG_ACTIVE_I) begin
        r_next.left = 1'b1;
      end else if (r_reg.left) begin
        r_next.ack   = r_reg.ack_en;  // RULE_19 RULE_20
        r_next.state = S_IDLE;
      end
      default: r_next.state = S_IDLE;
    endcase

    // decode of a newly taken frame; overrides a pending S_RETURN wait
    if (accept) begin
      r_next.state = S_IDLE;
      r_next.ack   = 1'b0;
      r_next.op    = CMD_OPCODE_I;
      r_next.wdata = CMD_DATA_I;
      r_next.left  = 1'b0;
      r_next.lanes = bdcu_lanes(CMD_OPCODE_I[OPB_WORD], CMD_ADDR_I[0]);
      // word accesses drop the address lsb
      r_next.addr  = CMD_OPCODE_I[OPB_WORD] && is_mem ?
                     {CMD_ADDR_I[15:1], 1'b0} : CMD_ADDR_I;  // RULE_12
      case (CMD_OPCODE_I)
        OP_BACKGROUND: if (DEBUG_ENABLE_I) begin  // RULE_23
          r_next.bg_req = 1'b1;  // RULE_07
          if (DEBUG_ACTIVE_I) begin
            r_next.ack = r_reg.ack_en;
          end else begin
            r_next.state = S_ENTER;
          end
        end
        OP_ACK_ON: begin
          r_next.ack_en = 1'b1;  // RULE_08
          r_next.ack    = 1'b1;
        end
        OP_ACK_OFF: begin
          r_next.ack_en = 1'b0;  // RULE_08
        end
        OP_RESUME, OP_RETIRED_RESUME: if (DEBUG_ACTIVE_I) begin  // RULE_21
          r_next.resume = 1'b1;  // RULE_18
          r_next.state  = S_LEAVE;
        end
        OP_RESUME_UNTIL: if (DEBUG_ACTIVE_I) begin
          r_next.resume = 1'b1;  // RULE_19
          r_next.state  = S_RETURN;
        end
        OP_STEP: if (DEBUG_ACTIVE_I) begin
          r_next.step  = 1'b1;  // RULE_20
          r_next.state = S_RETURN;
        end
        default: begin
          if (is_mem) begin
            r_next.state = S_HW;  // RULE_04
          end else if (is_fw && DEBUG_ACTIVE_I) begin
            r_next.state = S_FW;  // RULE_13 RULE_15
          end
          // anything else falls through silently
        end
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge RESET_N_I) begin
    if (!RESET_N_I) begin
      r_reg <= TOP_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // steal engine request
  assign acc_bus.req   = (r_reg.state == S_HW);
  assign acc_bus.we    = !r_reg.op[OPB_READ];  // RULE_10
  assign acc_bus.lanes = r_reg.lanes;

  // memory bus data from the latched frame
  assign MEM_WE_O     = acc_bus.we;
  assign MEM_LANES_O  = r_reg.lanes;
  assign MEM_ADDR_O   = r_reg.addr;
  assign MEM_WDATA_O  = r_reg.wdata;
  // debug space overlays the application only in the actual access cycle
  assign MEM_BD_MAP_O = MEM_REQ_O && r_reg.op[OPB_BDMAP];  // RULE_05

  // firmware handoff; next-word opcodes leave the x+2 step to the firmware
  assign FW_REQ_O   = (r_reg.state == S_FW);  // RULE_16
  assign FW_CODE_O  = r_reg.op;
  assign FW_WDATA_O = r_reg.wdata;

  // debug window overlays 0x3_FF00..0x3_FFFF for as long as debug mode lasts
  assign DEBUG_MAP_O = DEBUG_ACTIVE_I;  // RULE_14

  // answers
  assign CMD_READY_O   = accept || (r_reg.state == S_IDLE);
  assign RESP_VALID_O  = r_reg.resp_valid;
  assign RESP_DATA_O   = r_reg.resp_data;
  assign ACK_PULSE_O   = r_reg.ack;
  assign ACK_ENABLED_O = r_reg.ack_en;
  assign BG_REQ_O      = r_reg.bg_req;
  assign RESUME_O      = r_reg.resume;
  assign STEP_O        = r_reg.step;

  chk_ack_on_pulse: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_08
    (accept && CMD_OPCODE_I == OP_ACK_ON) |=> (ACK_PULSE_O && ACK_ENABLED_O))
    else $error("handshake enable gave no pulse");

  chk_ack_off_quiet: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_08
    (accept && CMD_OPCODE_I == OP_ACK_OFF) |=> (!ACK_PULSE_O && !ACK_ENABLED_O))
    else $error("handshake disable misbehaved");

  chk_ack_gated: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_06
    ACK_PULSE_O |-> ACK_ENABLED_O ##1 !ACK_PULSE_O)
    else $error("ack pulse without handshake or too long");

  chk_bg_ignored: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_23
    (accept && CMD_OPCODE_I == OP_BACKGROUND && !DEBUG_ENABLE_I)
      |=> (!BG_REQ_O && CMD_READY_O && !ACK_PULSE_O))
    else $error("entry command acted while disabled");

  chk_fw_outside: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_25
    (accept && is_fw && !DEBUG_ACTIVE_I) |=> (!FW_REQ_O && !ACK_PULSE_O))
    else $error("register command ran outside debug mode");

  chk_hw_read_ack: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_06
    (r_reg.state == S_HW && acc_bus.done && r_reg.op[OPB_READ])
      |=> (RESP_VALID_O && ACK_PULSE_O == ACK_ENABLED_O))
    else $error("read data or ack missing");

  chk_byte_lane: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_11
    (RESP_VALID_O && r_reg.lanes == 2'h1) |-> (RESP_DATA_O[15:8] == 8'h00))
    else $error("odd byte not in low lane");

  chk_bd_map_cycle: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_05
    MEM_BD_MAP_O |-> (MEM_REQ_O && r_reg.state == S_HW))
    else $error("debug space mapped outside access");

  chk_hw_any_mode: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_04
    (accept && is_mem) |=> acc_bus.req)
    else $error("memory command not started");

  chk_resume_leave: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_18
    (r_reg.state == S_LEAVE && !DEBUG_ACTIVE_I) |=> (ACK_PULSE_O == ACK_ENABLED_O))
    else $error("resume ack not on leaving");

  // execution control, answer data and lane placement
  chk_bg_pulse: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_07
    (accept && CMD_OPCODE_I == OP_BACKGROUND && DEBUG_ENABLE_I) |=> BG_REQ_O)
    else $error("entry request missing");

  chk_entry_ack: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_07
    (r_reg.state == S_ENTER && DEBUG_ACTIVE_I) |=> (ACK_PULSE_O == ACK_ENABLED_O))
    else $error("entry ack wrong");

  chk_return_quiet: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_19
    (r_reg.state == S_RETURN && !DEBUG_ACTIVE_I) |=> !ACK_PULSE_O)
    else $error("ack before return");

  chk_step_pulse: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_20
    (accept && CMD_OPCODE_I == OP_STEP && DEBUG_ACTIVE_I) |=> (STEP_O && !RESUME_O))
    else $error("step pulse wrong");

  chk_retired_go: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_21
    (accept && CMD_OPCODE_I == OP_RETIRED_RESUME && DEBUG_ACTIVE_I) |=> (RESUME_O && !STEP_O))
    else $error("retired opcode not resume");

  chk_go_outside: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_13
    (accept && CMD_OPCODE_I == OP_RESUME && !DEBUG_ACTIVE_I) |=> !RESUME_O)
    else $error("resume outside debug mode");

  chk_fw_answer: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_17
    (r_reg.state == S_FW && FW_DONE_I && r_reg.op[OPB_READ])
      |=> (RESP_VALID_O && RESP_DATA_O == $past(FW_RDATA_I)))
    else $error("register read data lost");

  chk_write_ack: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_06
    (r_reg.state == S_HW && acc_bus.done && !r_reg.op[OPB_READ])
      |=> (!RESP_VALID_O && ACK_PULSE_O == ACK_ENABLED_O))
    else $error("write ack wrong");

  chk_lane_even: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_11
    (RESP_VALID_O && r_reg.lanes == 2'h2 && bdcu_is_mem(r_reg.op))
      |-> (RESP_DATA_O[7:0] == 8'h00))
    else $error("even byte not in high lane");

  chk_word_even: assert property (@(posedge CLK_I) disable iff (!RESET_N_I) // RULE_12
    (MEM_REQ_O && MEM_LANES_O == 2'h3) |-> !MEM_ADDR_O[0])
    else $error("word access at odd address");

endmodule : bdcu_top

/* bdcu_host_model.sv */
module bdcu_host_model (
  // clock
  input  wire logic        clk_i,
  // command port of the unit
  input  wire logic        ready_i,
  output      logic        valid_o,
  output      logic [7:0]  op_o,
  output      logic [15:0] addr_o,
  output      logic [15:0] data_o
);
  timeunit 1ns;
  timeprecision 1ns;

  int stuck = 0;

  // nothing offered before the first frame
  initial begin
    valid_o = 1'b0;
    op_o    = 8'h00;
    addr_o  = 16'h0000;
    data_o  = 16'h0000;
  end

  // one frame held until the unit takes it at a rising edge
  task automatic send(input logic [7:0] op, input logic [15:0] addr, input logic [15:0] data);
    int n;
    n = 0;
    @(negedge clk_i);
    op_o    = op;
    addr_o  = op[3] ? {addr[15:1], 1'b0} : addr;
    data_o  = data;
    valid_o = 1'b1;
    while (!ready_i && n < 500) begin
      n++;
      @(negedge clk_i);
    end
    if (n >= 500) stuck++;
    @(negedge clk_i);
    // released fields must not look like the last frame
    valid_o = 1'b0;
    op_o    = ~op;
    addr_o  = ~addr;
    data_o  = ~data;
  endtask : send
endmodule : bdcu_host_model

/* background_debug_command_unit_tb.sv */
module background_debug_command_unit_tb import bdcu_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;

  // short steal count keeps the run brief
  localparam int unsigned STEAL = 8;

  logic        CLK_I, RESET_N_I, DEBUG_ENABLE_I, DEBUG_ACTIVE_I, FW_DONE_I, BUS_IDLE_I;
  logic        CMD_VALID_I, CMD_READY_O, RESP_VALID_O, ACK_PULSE_O, ACK_ENABLED_O;
  logic        BG_REQ_O, RESUME_O, STEP_O, DEBUG_MAP_O, FW_REQ_O, MEM_REQ_O, MEM_WE_O;
  logic        MEM_BD_MAP_O, FREEZE_O, MEM_WAIT_I, bdmap, we;
  logic [7:0]  CMD_OPCODE_I, FW_CODE_O, fwcode;
  logic [1:0]  MEM_LANES_O, lanes;
  logic [15:0] CMD_ADDR_I, CMD_DATA_I, RESP_DATA_O, FW_WDATA_O, FW_RDATA_I, MEM_ADDR_O;
  logic [15:0] MEM_WDATA_O, resp_last, maddr, wdata, fwdata;
  logic [15:0] MEM_RDATA_I = 16'hB7E1;
  logic [15:0] acks, resps, bgs, rsm, stp, reqs, frz, fws;
  int          num_errors = 0, checked = 0, wcnt, back, wait_len, ret_after;
  logic [7:0]  m_op [8] = '{8'hE0, 8'hE4, 8'hE8, 8'hEC, 8'hC0, 8'hC4, 8'hC8, 8'hCC};
  logic [15:0] m_ad [8] = '{16'h1001, 16'h2000, 16'h2000, 16'h2002,
                            16'h1003, 16'h1004, 16'h2004, 16'h2006};

  // bus model stretches an access to last wait_len cycles
  assign MEM_WAIT_I = MEM_REQ_O && (wcnt < wait_len);

  bdcu_top #(.STEAL_CYCLES(STEAL)) i_bdcu_top (
    .CLK_I(CLK_I), .RESET_N_I(RESET_N_I), .CMD_VALID_I(CMD_VALID_I),
    .CMD_OPCODE_I(CMD_OPCODE_I), .CMD_ADDR_I(CMD_ADDR_I), .CMD_DATA_I(CMD_DATA_I),
    .CMD_READY_O(CMD_READY_O), .RESP_VALID_O(RESP_VALID_O), .RESP_DATA_O(RESP_DATA_O),
    .ACK_PULSE_O(ACK_PULSE_O), .ACK_ENABLED_O(ACK_ENABLED_O),
    .DEBUG_ENABLE_I(DEBUG_ENABLE_I), .DEBUG_ACTIVE_I(DEBUG_ACTIVE_I), .BG_REQ_O(BG_REQ_O),
    .RESUME_O(RESUME_O), .STEP_O(STEP_O), .DEBUG_MAP_O(DEBUG_MAP_O), .FW_REQ_O(FW_REQ_O),
    .FW_CODE_O(FW_CODE_O), .FW_WDATA_O(FW_WDATA_O), .FW_DONE_I(FW_DONE_I),
    .FW_RDATA_I(FW_RDATA_I), .BUS_IDLE_I(BUS_IDLE_I), .MEM_WAIT_I(MEM_WAIT_I),
    .MEM_RDATA_I(MEM_RDATA_I), .MEM_REQ_O(MEM_REQ_O), .MEM_WE_O(MEM_WE_O),
    .MEM_BD_MAP_O(MEM_BD_MAP_O), .MEM_LANES_O(MEM_LANES_O), .MEM_ADDR_O(MEM_ADDR_O),
    .MEM_WDATA_O(MEM_WDATA_O), .FREEZE_O(FREEZE_O)
  );

  bdcu_host_model i_bdcu_host_model (
    .clk_i(CLK_I), .ready_i(CMD_READY_O), .valid_o(CMD_VALID_I),
    .op_o(CMD_OPCODE_I), .addr_o(CMD_ADDR_I), .data_o(CMD_DATA_I)
  );

  initial begin
    CLK_I = 1'b0;
    forever #25 CLK_I = ~CLK_I;
  end

  // monitor counts one-cycle pulses and keeps what each access showed
  always @(posedge CLK_I) begin
    if (ACK_PULSE_O) acks <= acks + 1;
    if (RESP_VALID_O) begin
      resps <= resps + 1;
      resp_last <= RESP_DATA_O;
    end
    if (BG_REQ_O) bgs <= bgs + 1;
    if (RESUME_O) rsm <= rsm + 1;
    if (STEP_O) stp <= stp + 1;
    if (FW_REQ_O) begin
      fws <= fws + 1;
      fwcode <= FW_CODE_O;
      fwdata <= FW_WDATA_O;
    end
    if (MEM_REQ_O) begin
      reqs <= reqs + 1;
      if (FREEZE_O === 1'b1) frz <= frz + 1;
      lanes <= MEM_LANES_O;
      bdmap <= MEM_BD_MAP_O;
      we <= MEM_WE_O;
      maddr <= MEM_ADDR_O;
      wdata <= MEM_WDATA_O;
    end
  end

  // cpu, firmware and bus responders; a resume returns after ret_after cycles if set
  always @(negedge CLK_I) begin
    FW_DONE_I <= FW_REQ_O && !FW_DONE_I;
    FW_RDATA_I <= {8'hC3, FW_CODE_O};
    wcnt <= MEM_REQ_O ? wcnt + 1 : 0;
    if (BG_REQ_O && DEBUG_ENABLE_I) DEBUG_ACTIVE_I <= 1'b1;
    if (RESUME_O || STEP_O) begin
      DEBUG_ACTIVE_I <= 1'b0;
      back <= ret_after;
    end else if (back != 0) begin
      back <= back - 1;
      if (back == 1) DEBUG_ACTIVE_I <= 1'b1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic print_verdict;
    if (num_errors == 0 && checked > 0 && i_bdcu_host_model.stuck == 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict

  task automatic clr;
    {acks, resps, bgs, rsm, stp, reqs, frz, fws} = '0;
  endtask : clr

  task automatic idle(input int n);
    repeat (n) @(negedge CLK_I);
  endtask : idle

  task automatic send(input logic [7:0] op, input logic [15:0] a, input logic [15:0] d);
    i_bdcu_host_model.send(op, a, d);
  endtask : send

  task automatic wait_ready;
    int n;
    n = 0;
    while (!CMD_READY_O && n < 400) begin
      n++;
      @(negedge CLK_I);
    end
    check(n < 400, 1'b1);
    idle(2);
  endtask : wait_ready

  task automatic t_ack;
    check(ACK_ENABLED_O, ACK_EN_RST);
    clr();
    send(OP_ACK_ON, 16'h0000, 16'h0000);
    idle(3);
    check(acks, 1);
    clr();
    send(OP_ACK_OFF, 16'h0000, 16'h0000);
    idle(3);
    check(acks, 0);
    check(ACK_ENABLED_O, 1'b0);
    send(OP_ACK_ON, 16'h0000, 16'h0000);
    idle(3);
  endtask : t_ack

  task automatic t_mem;
    logic [7:0]  op;
    logic [15:0] a;
    for (int i = 0; i < 8; i++) begin
      op = m_op[i];
      a = m_ad[i];
      clr();
      send(op, a, 16'h5AA5);
      wait_ready();
      check(lanes, op[3] ? 2'h3 : {~a[0], a[0]});
      check(bdmap, op[2]);
      check(reqs, 1);
      check(frz, 0);
      check(we, !op[5]);
      check(maddr, a);
      check(acks, 1);
      check(resps, op[5]);
      if (op[5]) check(resp_last, op[3] ? 16'hB7E1 : (a[0] ? 16'h00E1 : 16'hB700));
      else check(wdata, 16'h5AA5);
    end
  endtask : t_mem

  task automatic t_steal;
    int n;
    n = 0;
    BUS_IDLE_I = 1'b0;
    clr();
    send(8'hE8, 16'h2000, 16'h0000);
    while (reqs == 0 && n < 300) begin
      n++;
      @(negedge CLK_I);
    end
    check(n >= STEAL && n <= STEAL + 5, 1'b1);
    check(n <= 150, 1'b1);
    check(frz != 0, 1'b1);
    wait_ready();
    check(resp_last, 16'hB7E1);
    clr();
    send(8'hE0, 16'h1001, 16'h0000);
    idle(2);
    BUS_IDLE_I = 1'b1;
    wait_ready();
    check(frz, 0);
    check(reqs, 1);
  endtask : t_steal

  task automatic t_multi;
    wait_len = 3;
    clr();
    send(8'hE0, 16'h1001, 16'h0000);
    wait_ready();
    check(reqs > 1, 1'b1);
    check(frz, reqs);
    check(resp_last, 16'h00E1);
    wait_len = 0;
  endtask : t_multi

  task automatic t_enter;
    DEBUG_ENABLE_I = 1'b0;
    clr();
    send(OP_BACKGROUND, 16'h0000, 16'h0000);
    send(8'h63, 16'h0000, 16'h0000);
    send(OP_RESUME, 16'h0000, 16'h0000);
    send(8'h77, 16'h0000, 16'h0000);
    idle(4);
    check(bgs, 0);
    check(frz, 0);
    check(fws, 0);
    check(rsm, 0);
    check(acks, 0);
    check(DEBUG_MAP_O, 1'b0);
    DEBUG_ENABLE_I = 1'b1;
    clr();
    send(OP_BACKGROUND, 16'h0000, 16'h0000);
    wait_ready();
    check(bgs, 1);
    check(acks, 1);
    check(DEBUG_MAP_O, 1'b1);
  endtask : t_enter

  task automatic t_fw;
    logic [7:0] op;
    for (int j = 0; j < 12; j++) begin
      op = (j < 6 ? 8'h62 : 8'h42) + 8'(j % 6);
      clr();
      send(op, 16'h0000, 16'h3C00 + 16'(j));
      wait_ready();
      check(fwcode, op);
      check(acks, 1);
      if (op[5]) check(resp_last, {8'hC3, op});
      else check(fwdata, 16'h3C00 + 16'(j));
    end
    send(8'hE4, 16'h2000, 16'h0000);
    wait_ready();
    check(resp_last, 16'hB700);
  endtask : t_fw

  task automatic t_go;
    logic [7:0] ops [4];
    ops = '{OP_RESUME, OP_RETIRED_RESUME, OP_RESUME_UNTIL, OP_STEP};
    for (int i = 0; i < 4; i++) begin
      ret_after = (i < 2) ? 0 : 8;
      clr();
      send(ops[i], 16'h0000, 16'h0000);
      idle(4);
      if (i >= 2) check(acks, 0);
      idle(14);
      check(acks, 1);
      check(i == 3 ? stp : rsm, 1);
      if (i < 2) begin
        send(OP_BACKGROUND, 16'h0000, 16'h0000);
        wait_ready();
      end
    end
    ret_after = 0;
  endtask : t_go

  initial begin
    RESET_N_I = 1'b0;
    DEBUG_ENABLE_I = 1'b0;
    DEBUG_ACTIVE_I = 1'b0;
    FW_DONE_I = 1'b0;
    FW_RDATA_I = 16'h0000;
    BUS_IDLE_I = 1'b1;
    wait_len = 0;
    ret_after = 0;
    wcnt = 0;
    back = 0;
    clr();
    repeat (3) @(posedge CLK_I);
    @(negedge CLK_I);
    RESET_N_I = 1'b1;
    t_ack();
    t_mem();
    t_steal();
    t_multi();
    t_enter();
    t_fw();
    t_go();
    print_verdict();
  end

  // watchdog: whole sequence needs well under two thousand cycles
  initial begin
    #2000000;
    num_errors++;
    print_verdict();
  end
endmodule : background_debug_command_unit_tb
